// *** core/arss_defines.svh ***
`ifndef ARSS_DEFINES_SVH
`define ARSS_DEFINES_SVH

// Register byte offsets on the plain register port
`define ARSS_ADDR_W 10
`define ARSS_RESULT_PAGE 6'h3C
`define ARSS_OFF_CTRL_TWO 10'h3D4
`define ARSS_OFF_CTRL_ZERO 10'h3D6
`define ARSS_OFF_CTRL_ONE 10'h3D7

// Reset values
`define ARSS_CTRL_ZERO_RESET 8'h00
`define ARSS_CTRL_ONE_RESET 8'h00
`define ARSS_CTRL_TWO_RESET 8'h00
`define ARSS_RESULT_RESET 10'h000

// Control register zero fields
`define ARSS_Z_CH_LO 0
`define ARSS_Z_CH_HI 2
`define ARSS_Z_MODE_LO 3
`define ARSS_Z_MODE_HI 4
`define ARSS_Z_TRIG_SEL 5
`define ARSS_Z_START 6
`define ARSS_Z_CKS_LO 7

// Control register one fields
`define ARSS_O_SCAN_LO 0
`define ARSS_O_SCAN_HI 1
`define ARSS_O_EXT_MODE 2
`define ARSS_O_BITS 3
`define ARSS_O_CKS_HI 4
`define ARSS_O_REF 5
`define ARSS_O_ROUTE_LO 6
`define ARSS_O_ROUTE_HI 7

// Control register two fields
`define ARSS_T_GROUP_LO 1
`define ARSS_T_GROUP_HI 2

// Mode field codes
`define ARSS_MODE_REPEAT 2'h1
`define ARSS_MODE_SWEEP 2'h2

// Converter clock ticks per conversion
`define ARSS_TICKS_8BIT 6'h1C
`define ARSS_TICKS_10BIT 6'h21

// Converter clock divide ratios by divider select code
`define ARSS_DIV_00 3'h4
`define ARSS_DIV_01 3'h2
`define ARSS_DIV_10 3'h3
`define ARSS_DIV_11 3'h6

`endif

// *** core/arss_pkg.sv ***
package arss_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT_TRIG,
    SEQ_START,
    SEQ_BUSY
  } arss_seq_state_t;

  // One conversion result, right aligned
  typedef logic [9:0] arss_result_t;

endpackage : arss_pkg

// *** core/arss_conv_if.sv ***
`timescale 1ns/1ps
interface arss_conv_if;
  logic start;
  logic abort;
  logic tenBit;
  logic done;
  logic [9:0] result;

  modport seq (output start, output abort, output tenBit, input done, input result);
  modport eng (input start, input abort, input tenBit, output done, output result);
endinterface : arss_conv_if

// *** core/arss_conv_engine.sv ***
`timescale 1ns/1ps
`include "arss_defines.svh"
module arss_conv_engine
  import arss_pkg::*;
(
  input wire logic mclk,
  input wire logic rstSyncN,
  input wire logic convTick,
  input wire logic [9:0] sarCode,
  arss_conv_if.eng conv
);

  logic busy_reg;
  logic [5:0] tickCnt_reg;
  logic tenBit_reg;
  logic done_reg;
  arss_result_t result_reg;
  logic [5:0] tickTarget;

  // Length follows the resolution latched at start
  assign tickTarget = tenBit_reg ? `ARSS_TICKS_10BIT : `ARSS_TICKS_8BIT;
  assign conv.done = done_reg;
  assign conv.result = result_reg;

  // Busy and tick counting; abort wins so a stopped run never completes
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      busy_reg <= 1'b0;
      tickCnt_reg <= 6'h00;
      tenBit_reg <= 1'b0;
    end
    else if (conv.abort)
    begin
      busy_reg <= 1'b0;
      tickCnt_reg <= 6'h00;
    end
    else if (conv.start)
    begin
      busy_reg <= 1'b1;
      tickCnt_reg <= 6'h00;
      tenBit_reg <= conv.tenBit;
    end
    else if (busy_reg && convTick)
    begin
      if (tickCnt_reg == tickTarget - 6'h01)
      begin
        busy_reg <= 1'b0;
        tickCnt_reg <= 6'h00;
      end
      else
      begin
        tickCnt_reg <= tickCnt_reg + 6'h01;
      end
    end
  end

  // Completion pulse and captured code
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      done_reg <= 1'b0;
      result_reg <= `ARSS_RESULT_RESET;
    end
    else
    begin
      done_reg <= busy_reg && convTick && !conv.abort && !conv.start
                  && (tickCnt_reg == tickTarget - 6'h01);
      if (busy_reg && convTick && (tickCnt_reg == tickTarget - 6'h01))
      begin
        result_reg <= tenBit_reg ? sarCode : {2'b00, sarCode[9:2]};
      end
    end
  end

  property p_eight_bit_range;
    @(posedge mclk) disable iff (!rstSyncN)
    (done_reg && !tenBit_reg) |-> (result_reg == ($past(sarCode) >> 2));
  endproperty
  a_eight_bit_range: assert property (p_eight_bit_range)
    else $error("8-bit result has upper bits set");

  property p_done_after_start;
    @(posedge mclk) disable iff (!rstSyncN)
    done_reg |-> $past(busy_reg) && $past(convTick);
  endproperty
  a_done_after_start: assert property (p_done_after_start)
    else $error("completion without a running conversion");

endmodule : arss_conv_engine

// *** core/arss_sequencer.sv ***
// Operation
// - Repeat mode reconverts the one selected input after each completion.
// - Mode field 01 selects repeat, 10 selects single sweep.
// - Software trigger starts conversion once the start flag is written 1.
// - External trigger starts on a falling pin edge after the start flag is set.
// - Repeat mode stops only when the start flag clears; no interrupt.
// - Single sweep converts each input of the range once, then stops.
// - Sweep end under software trigger clears the start flag; software may abort.
// - Single sweep raises the interrupt request when the sweep completes.
// - Sweep range 00,01,10,11 covers inputs 0-1, 0-3, 0-5, 0-7.
// - Channel field picks input 0 to 7 in straight binary in repeat mode.
// - Channel field unused in sweep; sweep range unused in repeat.
// - Resolution bit selects 8-bit results at 0, 10-bit at 1.
// - Eight result registers, each conversion stored at its input position.
// - Repeat input chosen by channel, group and external route fields.
// - Three alternate input groups work like the primary group via group select.
`timescale 1ns/1ps
`include "arss_defines.svh"
module arss_sequencer
  import arss_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`ARSS_ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  input wire logic externalTriggerPin,
  input wire logic [9:0] sarCode,
  output logic convIrq,
  output logic convActive,
  output logic [2:0] muxChannel,
  output logic [1:0] muxGroup,
  output logic [1:0] muxRoute,
  output logic refConnect
);

  logic rstMeta_reg;
  logic rstSyncN;
  logic [7:0] ctrlZero_reg;
  logic [7:0] ctrlOne_reg;
  logic [7:0] ctrlTwo_reg;
  logic startFlag_reg;
  logic startFlag_next;
  arss_result_t resultMem_reg [0:7];
  arss_seq_state_t seqState;
  logic [2:0] sweepPos_reg;
  logic [2:0] convPos_reg;
  logic [2:0] divCnt_reg;
  logic [2:0] divRatio;
  logic convTick_reg;
  logic trigMeta_reg;
  logic trigSyncA_reg;
  logic trigSyncB_reg;
  logic trigStable_reg;
  logic trigFall;
  logic [7:0] rdData_reg;
  logic convIrq_reg;
  logic convActive_reg;
  logic [2:0] muxChannel_reg;
  logic [1:0] muxGroup_reg;
  logic [1:0] muxRoute_reg;
  logic wrCtrlZero;
  logic wrCtrlOne;
  logic wrCtrlTwo;
  logic [1:0] modeCode;
  logic modeRepeat;
  logic modeSweep;
  logic trigSel;
  logic runOk;
  logic [2:0] sweepLastPos;
  logic sweepLast;
  logic [2:0] curChan;
  logic convDone;
  logic sweepDone;

  arss_conv_if conv ();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_reg <= 1'b0;
      rstSyncN <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      rstSyncN <= rstMeta_reg;
    end
  end

  // Address decode
  assign wrCtrlZero = wrStb && (addr == `ARSS_OFF_CTRL_ZERO);
  assign wrCtrlOne = wrStb && (addr == `ARSS_OFF_CTRL_ONE);
  assign wrCtrlTwo = wrStb && (addr == `ARSS_OFF_CTRL_TWO);

  // Field views of the control registers
  assign modeCode = ctrlZero_reg[`ARSS_Z_MODE_HI:`ARSS_Z_MODE_LO];
  assign modeRepeat = (modeCode == `ARSS_MODE_REPEAT);
  assign modeSweep = (modeCode == `ARSS_MODE_SWEEP);
  assign trigSel = ctrlZero_reg[`ARSS_Z_TRIG_SEL];
  assign runOk = startFlag_reg && (modeRepeat || modeSweep);
  // Range code n ends at input 2n+1, so the last position is the code with a 1 appended
  assign sweepLastPos = {ctrlOne_reg[`ARSS_O_SCAN_HI:`ARSS_O_SCAN_LO], 1'b1};
  assign sweepLast = (sweepPos_reg == sweepLastPos);
  // Channel field only counts in repeat mode, sweep position only in sweep
  assign curChan = modeRepeat ? ctrlZero_reg[`ARSS_Z_CH_HI:`ARSS_Z_CH_LO]
                              : sweepPos_reg;
  assign convDone = (seqState == SEQ_BUSY) && conv.done && runOk;
  assign sweepDone = convDone && modeSweep && sweepLast;

  // Control registers zero (without start flag), one and two
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      ctrlZero_reg <= `ARSS_CTRL_ZERO_RESET;
      ctrlOne_reg <= `ARSS_CTRL_ONE_RESET;
      ctrlTwo_reg <= `ARSS_CTRL_TWO_RESET;
    end
    else
    begin
      if (wrCtrlZero)
      begin
        ctrlZero_reg <= wrData;
      end
      if (wrCtrlOne)
      begin
        ctrlOne_reg <= wrData;
      end
      if (wrCtrlTwo)
      begin
        ctrlTwo_reg <= wrData;
      end
    end
  end

  // Start flag: a software write beats the hardware clear in the same cycle
  always_comb
  begin
    startFlag_next = startFlag_reg;
    if (sweepDone && !trigSel)
    begin
      startFlag_next = 1'b0;
    end
    if (wrCtrlZero)
    begin
      startFlag_next = wrData[`ARSS_Z_START];
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      startFlag_reg <= 1'b0;
    end
    else
    begin
      startFlag_reg <= startFlag_next;
    end
  end

  // Converter clock divider, free running so the tick phase is steady
  always_comb
  begin
    unique case ({ctrlOne_reg[`ARSS_O_CKS_HI], ctrlZero_reg[`ARSS_Z_CKS_LO]})
      2'b00: divRatio = `ARSS_DIV_00;
      2'b01: divRatio = `ARSS_DIV_01;
      2'b10: divRatio = `ARSS_DIV_10;
      2'b11: divRatio = `ARSS_DIV_11;
    endcase
  end

  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      divCnt_reg <= 3'h0;
      convTick_reg <= 1'b0;
    end
    else if (divCnt_reg >= divRatio - 3'h1)
    begin
      divCnt_reg <= 3'h0;
      convTick_reg <= 1'b1;
    end
    else
    begin
      divCnt_reg <= divCnt_reg + 3'h1;
      convTick_reg <= 1'b0;
    end
  end

  // Trigger pin: three flops, a level counts once the last two agree
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      trigMeta_reg <= 1'b1;
      trigSyncA_reg <= 1'b1;
      trigSyncB_reg <= 1'b1;
      trigStable_reg <= 1'b1;
    end
    else
    begin
      trigMeta_reg <= externalTriggerPin;
      trigSyncA_reg <= trigMeta_reg;
      trigSyncB_reg <= trigSyncA_reg;
      if (trigSyncA_reg == trigSyncB_reg)
      begin
        trigStable_reg <= trigSyncB_reg;
      end
    end
  end

  // Falling edge of the agreed level
  assign trigFall = trigStable_reg && !trigSyncA_reg && !trigSyncB_reg;

  // Sequencer; clearing the start flag stops any stage at once
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      seqState <= SEQ_IDLE;
    end
    else if (!runOk)
    begin
      seqState <= SEQ_IDLE;
    end
    else
    begin
      unique case (seqState)
        SEQ_IDLE: seqState <= trigSel ? SEQ_WAIT_TRIG : SEQ_START;
        SEQ_WAIT_TRIG:
        begin
          if (trigFall)
          begin
            seqState <= SEQ_START;
          end
        end
        SEQ_START: seqState <= SEQ_BUSY;
        SEQ_BUSY:
        begin
          if (conv.done)
          begin
            if (modeRepeat || !sweepLast)
            begin
              seqState <= SEQ_START;
            end
            else
            begin
              // External trigger re-arms for the next sweep
              seqState <= trigSel ? SEQ_WAIT_TRIG : SEQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Sweep position walks upward from input 0
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      sweepPos_reg <= 3'h0;
    end
    else if (seqState == SEQ_IDLE || seqState == SEQ_WAIT_TRIG || sweepDone)
    begin
      sweepPos_reg <= 3'h0;
    end
    else if (convDone && modeSweep)
    begin
      sweepPos_reg <= sweepPos_reg + 3'h1;
    end
  end

  // Position latched per conversion so the result lands where it was sampled
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      convPos_reg <= 3'h0;
    end
    else if (seqState == SEQ_START)
    begin
      convPos_reg <= curChan;
    end
  end

  // Engine handshake
  assign conv.start = (seqState == SEQ_START) && runOk;
  assign conv.abort = !runOk;
  assign conv.tenBit = ctrlOne_reg[`ARSS_O_BITS];

  arss_conv_engine u_arss_conv_engine (
    .mclk(mclk),
    .rstSyncN(rstSyncN),
    .convTick(convTick_reg),
    .sarCode(sarCode),
    .conv(conv)
  );

  // Result store, one register per input position
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      for (int i = 0; i < 8; i++)
      begin
        resultMem_reg[i] <= `ARSS_RESULT_RESET;
      end
    end
    else if (convDone)
    begin
      resultMem_reg[convPos_reg] <= conv.result;
    end
  end

  // Interrupt only from sweep completion, never from repeat mode
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      convIrq_reg <= 1'b0;
    end
    else
    begin
      convIrq_reg <= sweepDone;
    end
  end

  // Analog selection; route only applies in repeat mode
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      muxChannel_reg <= 3'h0;
      muxGroup_reg <= 2'h0;
      muxRoute_reg <= 2'h0;
      convActive_reg <= 1'b0;
    end
    else
    begin
      muxChannel_reg <= curChan;
      muxGroup_reg <= ctrlTwo_reg[`ARSS_T_GROUP_HI:`ARSS_T_GROUP_LO];
      muxRoute_reg <= modeRepeat ? ctrlOne_reg[`ARSS_O_ROUTE_HI:`ARSS_O_ROUTE_LO]
                                 : 2'h0;
      convActive_reg <= (seqState == SEQ_START) || (seqState == SEQ_BUSY);
    end
  end

  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      rdData_reg <= 8'h00;
    end
    else if (!rdStb)
    begin
      rdData_reg <= 8'h00;
    end
    else if (addr == `ARSS_OFF_CTRL_ZERO)
    begin
      rdData_reg <= {ctrlZero_reg[7], startFlag_reg, ctrlZero_reg[5:0]};
    end
    else if (addr == `ARSS_OFF_CTRL_ONE)
    begin
      rdData_reg <= ctrlOne_reg;
    end
    else if (addr == `ARSS_OFF_CTRL_TWO)
    begin
      rdData_reg <= ctrlTwo_reg;
    end
    else if (addr[9:4] == `ARSS_RESULT_PAGE)
    begin
      rdData_reg <= addr[0] ? {6'h00, resultMem_reg[addr[3:1]][9:8]}
                            : resultMem_reg[addr[3:1]][7:0];
    end
    else
    begin
      rdData_reg <= 8'h00;
    end
  end

  assign rdData = rdData_reg;
  assign convIrq = convIrq_reg;
  assign convActive = convActive_reg;
  assign muxChannel = muxChannel_reg;
  assign muxGroup = muxGroup_reg;
  assign muxRoute = muxRoute_reg;
  assign refConnect = ctrlOne_reg[`ARSS_O_REF];

  property p_repeat_restart;
    @(posedge mclk) disable iff (!rstSyncN)
    (convDone && modeRepeat) |=> (seqState == SEQ_START);
  endproperty
  a_repeat_restart: assert property (p_repeat_restart)
    else $error("repeat mode did not restart");

  property p_soft_start;
    @(posedge mclk) disable iff (!rstSyncN)
    (seqState == SEQ_IDLE && runOk && !trigSel) |=> (seqState == SEQ_START || !runOk);
  endproperty
  a_soft_start: assert property (p_soft_start)
    else $error("software trigger did not start");

  property p_wait_edge;
    @(posedge mclk) disable iff (!rstSyncN)
    (seqState == SEQ_WAIT_TRIG && !trigFall) |=> (seqState != SEQ_START);
  endproperty
  a_wait_edge: assert property (p_wait_edge)
    else $error("started without trigger edge");

  property p_irq_sweep_only;
    @(posedge mclk) disable iff (!rstSyncN)
    convIrq_reg |-> ($past(modeCode) == `ARSS_MODE_SWEEP);
  endproperty
  a_irq_sweep_only: assert property (p_irq_sweep_only)
    else $error("interrupt outside single sweep");

  property p_sweep_clear;
    @(posedge mclk) disable iff (!rstSyncN)
    (sweepDone && !trigSel && !wrCtrlZero) |=> !startFlag_reg ##1 (seqState == SEQ_IDLE);
  endproperty
  a_sweep_clear: assert property (p_sweep_clear)
    else $error("start flag not cleared after sweep");

  property p_sweep_irq;
    @(posedge mclk) disable iff (!rstSyncN)
    sweepDone |=> convIrq_reg ##1 !convIrq_reg;
  endproperty
  a_sweep_irq: assert property (p_sweep_irq)
    else $error("missing single-cycle sweep interrupt");

  property p_range_bound;
    @(posedge mclk) disable iff (!rstSyncN)
    (seqState == SEQ_BUSY && modeSweep) |-> (sweepPos_reg <= sweepLastPos);
  endproperty
  a_range_bound: assert property (p_range_bound)
    else $error("sweep position past range");

  property p_result_store;
    @(posedge mclk) disable iff (!rstSyncN)
    convDone |=> (resultMem_reg[$past(convPos_reg)] == $past(conv.result));
  endproperty
  a_result_store: assert property (p_result_store)
    else $error("result not stored at its position");

  property p_ascending;
    @(posedge mclk) disable iff (!rstSyncN)
    (convDone && modeSweep && !sweepLast) |=> (sweepPos_reg == $past(sweepPos_reg) + 3'h1);
  endproperty
  a_ascending: assert property (p_ascending)
    else $error("sweep did not advance by one");

endmodule : arss_sequencer

// *** verif/arss_front_model.sv ***
`timescale 1ns/1ps
module arss_front_model
  import arss_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] muxChannel,
  input wire logic [1:0] muxGroup,
  input wire logic [4:0] levelBias,
  input wire logic fireTrig,
  output arss_result_t sarCode,
  output logic externalTriggerPin
);
  logic [2:0] lowCnt;

  // Every input and group reads a distinct code, so a result filed at the wrong place shows
  assign sarCode = {muxChannel, muxGroup, levelBias};

  // Trigger pin idles high; held low four cycles so the synchroniser cannot miss the edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lowCnt <= 3'h0;
      externalTriggerPin <= 1'b1;
    end
    else if (fireTrig)
    begin
      lowCnt <= 3'h4;
      externalTriggerPin <= 1'b0;
    end
    else if (lowCnt != 3'h0)
    begin
      lowCnt <= lowCnt - 3'h1;
      externalTriggerPin <= (lowCnt == 3'h1);
    end
  end
endmodule : arss_front_model

// *** verif/adc_repeat_sweep_sequencer_tb.sv ***
`timescale 1ns/1ps
`include "arss_defines.svh"
module adc_repeat_sweep_sequencer_tb
  import arss_pkg::*;
;
  logic mclk, rst_n, wrStb, rdStb, fireTrig, rdSeen, tenBit;
  logic [`ARSS_ADDR_W-1:0] addr;
  logic [7:0] wrData, rdData;
  logic [4:0] levelBias;
  logic externalTriggerPin, convIrq, convActive, refConnect;
  logic [2:0] muxChannel, ch;
  logic [1:0] muxGroup, muxRoute, grp, route;
  arss_result_t sarCode;
  logic [7:0] expQ[$];
  int error_cnt, cmp_count, irqCnt, cycles, n0, i;

  arss_sequencer u_arss_sequencer (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .externalTriggerPin(externalTriggerPin),
    .sarCode(sarCode), .convIrq(convIrq), .convActive(convActive), .muxChannel(muxChannel),
    .muxGroup(muxGroup), .muxRoute(muxRoute), .refConnect(refConnect));

  arss_front_model u_arss_front_model (.mclk(mclk), .rst_n(rst_n), .muxChannel(muxChannel),
    .muxGroup(muxGroup), .levelBias(levelBias), .fireTrig(fireTrig), .sarCode(sarCode),
    .externalTriggerPin(externalTriggerPin));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Read data stand only in the cycle after the strobe, so the oldest note is taken there
  always @(posedge mclk)
  begin
    cycles++;
    if (convIrq === 1'b1)
      irqCnt++;
    if (rdSeen === 1'b1)
      check({2'h0, rdData}, {2'h0, expQ.pop_front()}, "register read");
    rdSeen <= rdStb;
    if (cycles >= 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    expQ.push_back(exp);
    @(posedge mclk);
    rdStb <= 1'b0;
  endtask : rd

  // Front-end code expected for an input, mirroring the analog side independently
  function automatic logic [9:0] code(input logic [2:0] c, input logic [1:0] g);
    return {c, g, levelBias};
  endfunction : code

  task automatic rdResult(input logic [2:0] n, input logic ten, input logic [9:0] c);
    if (ten)
    begin
      rd({`ARSS_RESULT_PAGE, n, 1'b0}, c[7:0]);
      rd({`ARSS_RESULT_PAGE, n, 1'b1}, {6'h00, c[9:8]});
    end
    else
      rd({`ARSS_RESULT_PAGE, n, 1'b0}, c[9:2]);
  endtask : rdResult

  // Divider code 01 (ratio 2) keeps every conversion short
  function automatic logic [7:0] ctlZero(input logic [2:0] c, input logic [1:0] m,
                                         input logic trig, input logic go);
    return {1'b1, go, trig, m, c};
  endfunction : ctlZero

  function automatic logic [7:0] ctlOne(input logic [1:0] s, input logic ten,
                                        input logic [1:0] r);
    return {r, 1'b1, 1'b0, ten, 1'b0, s};
  endfunction : ctlOne

  task automatic hold(input int n, input logic lvl);
    int bad;
    bad = 0;
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      if (convActive !== lvl)
        bad++;
    end
    check(10'(bad), 10'h000, "conversion activity");
  endtask : hold

  task automatic waitIrq(input int limit);
    int k;
    k = 0;
    while (convIrq !== 1'b1 && k < limit)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    check(10'(k < limit), 10'h001, "sweep end request");
    @(posedge mclk);
    #1;
    check({9'h000, convIrq}, 10'h000, "request pulse width");
  endtask : waitIrq

  initial
  begin
    rst_n = 1'b0;
    {wrStb, rdStb, fireTrig} = 3'h0;
    addr = 10'h000;
    wrData = 8'h00;
    levelBias = 5'h15;
    {error_cnt, cmp_count, irqCnt, cycles} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    void'($urandom(45449));
    // Register reset values, access and an unmapped place
    rd(`ARSS_OFF_CTRL_ZERO, 8'h00);
    rd(`ARSS_OFF_CTRL_ONE, 8'h00);
    rd(`ARSS_OFF_CTRL_TWO, 8'h00);
    wr(10'h3D0, 8'hFF);
    rd(10'h3D0, 8'h00);
    wr(`ARSS_OFF_CTRL_ONE, 8'hE9);
    rd(`ARSS_OFF_CTRL_ONE, 8'hE9);
    wr(`ARSS_OFF_CTRL_TWO, 8'h06);
    rd(`ARSS_OFF_CTRL_TWO, 8'h06);
    check({9'h000, refConnect}, 10'h001, "reference connect");
    for (int m = 0; m < 4; m += 3)
    begin
      wr(`ARSS_OFF_CTRL_ZERO, ctlZero(3'h0, 2'(m), 1'b0, 1'b1));
      hold(100, 1'b0);
      wr(`ARSS_OFF_CTRL_ZERO, 8'h00);
    end
    $display("test registers done");
    // Single sweep over every range, both resolutions, random group
    for (int s = 0; s < 4; s++)
    begin
      grp = 2'($urandom);
      ch = 3'($urandom);
      tenBit = s[0];
      wr(`ARSS_OFF_CTRL_TWO, {5'h00, grp, 1'b0});
      wr(`ARSS_OFF_CTRL_ONE, ctlOne(2'(s), tenBit, 2'h3));
      wr(`ARSS_OFF_CTRL_ZERO, ctlZero(ch, `ARSS_MODE_SWEEP, 1'b0, 1'b0));
      repeat (40) @(posedge mclk);
      n0 = irqCnt;
      wr(`ARSS_OFF_CTRL_ZERO, ctlZero(ch, `ARSS_MODE_SWEEP, 1'b0, 1'b1));
      waitIrq(2000);
      check(10'(irqCnt - n0), 10'h001, "requests per sweep");
      check({8'h00, muxRoute}, 10'h000, "route outside repeat");
      rd(`ARSS_OFF_CTRL_ZERO, ctlZero(ch, `ARSS_MODE_SWEEP, 1'b0, 1'b0));
      for (int n = 0; n <= 2 * s + 1; n++)
        rdResult(3'(n), tenBit, code(3'(n), grp));
      if (s == 0)
        rd({`ARSS_RESULT_PAGE, 4'h4}, 8'h00);
    end
    $display("test single sweep done");
    // Repeat mode: same input reconverted until the flag clears, never a request
    ch = 3'($urandom);
    grp = 2'($urandom);
    route = 2'($urandom);
    wr(`ARSS_OFF_CTRL_TWO, {5'h00, grp, 1'b0});
    wr(`ARSS_OFF_CTRL_ONE, ctlOne(2'h3, 1'b1, route));
    wr(`ARSS_OFF_CTRL_ZERO, ctlZero(3'h0, `ARSS_MODE_REPEAT, 1'b0, 1'b0));
    wr(`ARSS_OFF_CTRL_ZERO, ctlZero(ch, `ARSS_MODE_REPEAT, 1'b0, 1'b1));
    n0 = irqCnt;
    repeat (4) @(posedge mclk);
    hold(200, 1'b1);
    check({7'h00, muxChannel}, {7'h00, ch}, "repeat channel");
    check({8'h00, muxRoute}, {8'h00, route}, "repeat route");
    check({8'h00, muxGroup}, {8'h00, grp}, "repeat group");
    levelBias <= ~levelBias;
    hold(200, 1'b1);
    wr(`ARSS_OFF_CTRL_ZERO, ctlZero(ch, `ARSS_MODE_REPEAT, 1'b0, 1'b0));
    repeat (3) @(posedge mclk);
    hold(10, 1'b0);
    check(10'(irqCnt - n0), 10'h000, "repeat requests");
    rdResult(ch, 1'b1, code(ch, grp));
    $display("test repeat done");
    // External trigger: no start before the falling edge
    wr(`ARSS_OFF_CTRL_TWO, 8'h00);
    wr(`ARSS_OFF_CTRL_ONE, ctlOne(2'h0, 1'b0, 2'h0));
    wr(`ARSS_OFF_CTRL_ZERO, ctlZero(3'h0, `ARSS_MODE_SWEEP, 1'b1, 1'b0));
    wr(`ARSS_OFF_CTRL_ZERO, ctlZero(3'h0, `ARSS_MODE_SWEEP, 1'b1, 1'b1));
    hold(30, 1'b0);
    @(posedge mclk);
    fireTrig <= 1'b1;
    @(posedge mclk);
    fireTrig <= 1'b0;
    i = 0;
    while (convActive !== 1'b1 && i < 12)
    begin
      @(posedge mclk);
      #1;
      i++;
    end
    check(10'(i < 12), 10'h001, "trigger start");
    waitIrq(1000);
    rdResult(3'h0, 1'b0, code(3'h0, 2'h0));
    rdResult(3'h1, 1'b0, code(3'h1, 2'h0));
    wr(`ARSS_OFF_CTRL_ZERO, 8'h00);
    $display("test external trigger done");
    // Sweep halted early by software: no request afterwards
    wr(`ARSS_OFF_CTRL_ONE, ctlOne(2'h3, 1'b1, 2'h0));
    wr(`ARSS_OFF_CTRL_ZERO, ctlZero(3'h0, `ARSS_MODE_SWEEP, 1'b0, 1'b1));
    n0 = irqCnt;
    repeat (150) @(posedge mclk);
    wr(`ARSS_OFF_CTRL_ZERO, ctlZero(3'h0, `ARSS_MODE_SWEEP, 1'b0, 1'b0));
    repeat (3) @(posedge mclk);
    hold(600, 1'b0);
    check(10'(irqCnt - n0), 10'h000, "request after halt");
    $display("test sweep halt done");
    repeat (3) @(posedge mclk);
    check(10'(expQ.size()), 10'h000, "reads outstanding");
    report_and_stop();
  end
endmodule : adc_repeat_sweep_sequencer_tb
